// >>> pkg/adc_pkg.sv
// package of register map, field positions, reset values and timing counts
// assumes a 16-bit byte address space and a 125 MHz system clock
package adc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_RESULT_LO  = 16'hFF18;
    localparam logic [15:0] ADDR_RESULT_HI  = 16'hFF19;
    localparam logic [15:0] ADDR_REF_BOOST  = 16'hFF2E;
    localparam logic [15:0] ADDR_CHAN_SEL   = 16'hFF39;
    localparam logic [15:0] ADDR_TRIG_CTRL  = 16'hFF3A;
    localparam logic [15:0] ADDR_STATUS     = 16'hFF3C;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          TRIG_MODE_POS   = 7;
    localparam int          TRIG_SRC_POS    = 0;
    localparam int          NEG_REF_POS     = 7;
    localparam int          BOOST_EN_POS    = 1;
    localparam int          ST_BOOST_POS    = 0;
    localparam int          ST_CMP_POS      = 1;
    localparam int          ST_PROHIB_POS   = 2;
    localparam int          ST_FRESH_POS    = 3;
    localparam logic [7:0]  RST_TRIG_CTRL   = 8'h00;
    localparam logic [7:0]  RST_REF_BOOST   = 8'h00;
    localparam logic [3:0]  RST_CHAN_SEL    = 4'h0;
    localparam logic [11:0] RST_RESULT      = 12'h000;
    localparam logic [3:0]  CHAN_PROHIBITED = 4'h7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ         = 125;
    localparam int          BOOST_SETTLE_US = 10;
    localparam int          CMP_SETTLE_US   = 1;
    localparam int          BOOST_SETTLE_CYC = BOOST_SETTLE_US * CLK_MHZ;
    localparam int          CMP_SETTLE_CYC  = CMP_SETTLE_US * CLK_MHZ;
    localparam int          CNT_W           = 11;

    // booster settle tracker states
    typedef enum logic [2:0] {
        BST_OFF   = 3'b001,
        BST_WAIT  = 3'b010,
        BST_READY = 3'b100
    } boost_state_t;

endpackage

// >>> src/trig_select.sv
// hardware start trigger selection
// assumes timer interrupt pulses come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module trig_select (
    // trigger configuration
    input  wire logic trig_mode,
    input  wire logic trig_src,
    // timer events
    input  wire logic timer0_compare_irq,
    input  wire logic timer8b_irq,
    // start request
    output logic      hw_start
);

    // --------------------------------------------------------------
    // selected timer event starts a conversion only in timer mode
    // --------------------------------------------------------------
    always_comb begin
        if (!trig_mode) begin
            hw_start = 1'b0;                      // software mode [RULE_01]
        end else if (trig_src) begin
            hw_start = timer8b_irq;               // [RULE_02]
        end else begin
            hw_start = timer0_compare_irq;        // [RULE_02]
        end
    end

endmodule
`default_nettype wire

// >>> src/chan_decode.sv
// analog input channel decoder: one-hot input select and amplifier routing
// assumes amplifier in-use flags come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module chan_decode
    import adc_pkg::*;
#(
    parameter int N_IN = 16
) (
    // channel code
    input  wire logic [3:0]      chan_code,
    input  wire logic [2:0]      amp_in_use,
    // decoded select
    output logic [N_IN-1:0]      chan_onehot,
    output logic                 chan_prohibited,
    output logic [2:0]           amp_out_route
);

    logic [N_IN-1:0] legal;

    // --------------------------------------------------------------
    // legal codes: 0..6, 8..10, 11 and 15
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            localparam logic [3:0] CODE = 4'(gi);
            assign legal[gi]       = (gi <= 6) || (gi >= 8 && gi <= 10)  // [RULE_14]
                                   || (gi == 11) || (gi == 15);          // [RULE_19]
            assign chan_onehot[gi] = legal[gi] && (chan_code == CODE);
        end
    endgenerate

    // code 0111 and every unlisted code selects nothing
    assign chan_prohibited = ~|chan_onehot;                   // [RULE_14] [RULE_19]

    // amplifier outputs sit on inputs 1, 4 and 9
    assign amp_out_route[0] = amp_in_use[0] && chan_onehot[1]; // [RULE_18]
    assign amp_out_route[1] = amp_in_use[1] && chan_onehot[4]; // [RULE_18]
    assign amp_out_route[2] = amp_in_use[2] && chan_onehot[9]; // [RULE_18]

endmodule
`default_nettype wire

// >>> src/adc_ctrl.sv
// converter control: trigger, reference and booster control, result registers
// assumes a same-clock register port and a converter core on the same clock
//
// Notes on behaviour
// [RULE_01] trigger-mode bit 7: software or timer start
// [RULE_02] bit 0 picks which timer event starts
// [RULE_03] software rewrites trigger control only when stopped
// [RULE_04] reference bit 7: ground or external pin
// [RULE_05] reference bit 1 runs the booster
// [RULE_06] software waits 10 us before comparator enable
// [RULE_07] start 1 us after comparator, else discard
// [RULE_08] 12-bit result, top nibble zero, reload each end
// [RULE_09] high nibble upper byte, low byte lower
// [RULE_10] wide result read by one 16-bit access
// [RULE_11] read each result before reconfiguring writes
// [RULE_12] 8-bit register holds result bits 11..4
// [RULE_13] byte read of upper address gives 8-bit view
// [RULE_14] channel codes 0-6, 8-10 valid; 0111 prohibited
// [RULE_15] software writes zero to channel bits 7..4
// [RULE_16] software sets used pins to input mode
// [RULE_17] software never selects a digital I/O pin
// [RULE_18] in-use amplifier output may be conversion input
// [RULE_19] code 1011 input 11, 1111 input 15
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl
    import adc_pkg::*;
#(
    parameter int BOOST_WAIT = BOOST_SETTLE_CYC,
    parameter int CMP_WAIT   = CMP_SETTLE_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wide,
    output logic      [15:0] reg_rdata,
    // converter core
    input  wire logic        conversion_run,
    input  wire logic        comparator_enable,
    input  wire logic        conv_done,
    input  wire logic [11:0] sar_result,
    output logic             conv_start,
    // timer events
    input  wire logic        timer0_compare_irq,
    input  wire logic        timer8b_irq,
    // analog front end
    input  wire logic [2:0]  amp_in_use,
    output logic             neg_reference_select,
    output logic             booster_enable,
    output logic [15:0]      chan_onehot,
    output logic             chan_prohibited,
    output logic [2:0]       amp_out_route
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic              trig_mode_q;
    logic              trig_src_q;
    logic              neg_ref_q;
    logic              boost_q;
    logic [3:0]        chan_q;
    logic [11:0]       result_q;
    logic              fresh_q;
    logic [15:0]       rdata_q;
    logic [15:0]       rdata_d;
    boost_state_t      bst_q;
    logic [CNT_W-1:0]  bcnt_q;
    logic [CNT_W-1:0]  ccnt_q;
    logic              cmp_ready_q;
    logic              wr_trig;
    logic              wr_ref;
    logic              wr_chan;
    logic              rd_result;
    logic [7:0]        status;

    localparam logic [CNT_W-1:0] BOOST_LAST = CNT_W'(BOOST_WAIT - 1);
    localparam logic [CNT_W-1:0] CMP_LAST   = CNT_W'(CMP_WAIT - 1);

    // write decode
    assign wr_trig = reg_wr && (reg_addr == ADDR_TRIG_CTRL);
    assign wr_ref  = reg_wr && (reg_addr == ADDR_REF_BOOST);
    assign wr_chan = reg_wr && (reg_addr == ADDR_CHAN_SEL);
    // any read that touches the result bytes
    assign rd_result = reg_rd && ((reg_addr == ADDR_RESULT_LO) || (reg_addr == ADDR_RESULT_HI));

    // ------------------------------------------------------------------
    // trigger control register
    // ------------------------------------------------------------------
    // writes are accepted at any time; software keeps them to stopped phases
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            trig_mode_q <= RST_TRIG_CTRL[TRIG_MODE_POS];
            trig_src_q  <= RST_TRIG_CTRL[TRIG_SRC_POS];
        end else if (wr_trig) begin
            trig_mode_q <= reg_wdata[TRIG_MODE_POS];  // [RULE_01] [RULE_03]
            trig_src_q  <= reg_wdata[TRIG_SRC_POS];   // [RULE_02]
        end
    end

    // ------------------------------------------------------------------
    // reference and booster control register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            neg_ref_q <= RST_REF_BOOST[NEG_REF_POS];
            boost_q   <= RST_REF_BOOST[BOOST_EN_POS];
        end else if (wr_ref) begin
            neg_ref_q <= reg_wdata[NEG_REF_POS];      // [RULE_04]
            boost_q   <= reg_wdata[BOOST_EN_POS];     // [RULE_05]
        end
    end

    assign neg_reference_select = neg_ref_q;          // [RULE_04]
    assign booster_enable       = boost_q;            // [RULE_05]

    // ------------------------------------------------------------------
    // channel select register
    // ------------------------------------------------------------------
    // only the low nibble is stored; the upper bits always read zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            chan_q <= RST_CHAN_SEL;
        end else if (wr_chan) begin
            chan_q <= reg_wdata[3:0];                 // [RULE_15] [RULE_11]
        end
    end

    // ------------------------------------------------------------------
    // result register
    // ------------------------------------------------------------------
    // reloaded at every conversion end; a reconfiguring write leaves it as is
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            result_q <= RST_RESULT;
        end else if (conv_done) begin
            result_q <= sar_result;                   // [RULE_08]
        end
    end

    // fresh flag: set on conversion end, cleared by a result read, set wins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fresh_q <= 1'b0;
        end else if (conv_done) begin
            fresh_q <= 1'b1;                          // [RULE_11]
        end else if (rd_result) begin
            fresh_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // booster settle tracker
    // ------------------------------------------------------------------
    // shows software when the reference has had its settle time
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bst_q  <= BST_OFF;
            bcnt_q <= '0;
        end else begin
            case (bst_q)
                BST_OFF: begin
                    bcnt_q <= '0;
                    if (boost_q) begin
                        bst_q <= BST_WAIT;
                    end
                end
                BST_WAIT: begin
                    if (!boost_q) begin
                        bst_q <= BST_OFF;
                    end else if (bcnt_q == BOOST_LAST) begin
                        bst_q <= BST_READY;           // [RULE_06]
                    end else begin
                        bcnt_q <= bcnt_q + 1'b1;
                    end
                end
                BST_READY: begin
                    if (!boost_q) begin
                        bst_q <= BST_OFF;
                    end
                end
                default: begin
                    bst_q <= BST_OFF;
                end
            endcase
        end
    end

    // comparator settle counter, restarted whenever the comparator is off
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ccnt_q      <= '0;
            cmp_ready_q <= 1'b0;
        end else if (!comparator_enable) begin
            ccnt_q      <= '0;
            cmp_ready_q <= 1'b0;
        end else if (ccnt_q == CMP_LAST) begin
            cmp_ready_q <= 1'b1;                      // [RULE_07]
        end else begin
            ccnt_q <= ccnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    assign status = {4'h0, fresh_q, chan_prohibited, cmp_ready_q, (bst_q == BST_READY)};

    // read data stand for one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_RESULT_LO: begin
                    if (reg_wide) begin
                        rdata_d = {4'h0, result_q};              // [RULE_08] [RULE_10]
                    end else begin
                        rdata_d = {8'h00, result_q[7:0]};        // [RULE_09]
                    end
                end
                ADDR_RESULT_HI: begin
                    if (!reg_wide) begin
                        rdata_d = {8'h00, result_q[11:4]};       // [RULE_12] [RULE_13]
                    end
                end
                ADDR_REF_BOOST: begin
                    rdata_d = {8'h00, neg_ref_q, 5'h00, boost_q, 1'b0};
                end
                ADDR_CHAN_SEL: begin
                    rdata_d = {12'h000, chan_q};
                end
                ADDR_TRIG_CTRL: begin
                    rdata_d = {8'h00, trig_mode_q, 6'h00, trig_src_q};
                end
                ADDR_STATUS: begin
                    rdata_d = {8'h00, status};
                end
                default: begin
                    rdata_d = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // trigger and channel decode
    // ------------------------------------------------------------------
    trig_select u_trig (
        .trig_mode          (trig_mode_q),
        .trig_src           (trig_src_q),
        .timer0_compare_irq (timer0_compare_irq),
        .timer8b_irq        (timer8b_irq),
        .hw_start           (conv_start)
    );

    chan_decode #(
        .N_IN (16)
    ) u_chan (
        .chan_code       (chan_q),
        .amp_in_use      (amp_in_use),
        .chan_onehot     (chan_onehot),
        .chan_prohibited (chan_prohibited),
        .amp_out_route   (amp_out_route)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_ref_write;
        reg_wr && (reg_addr == ADDR_REF_BOOST);
    endsequence

    sequence s_wide_read;
        reg_rd && reg_wide && (reg_addr == ADDR_RESULT_LO);
    endsequence

    sequence s_byte_hi_read;
        reg_rd && !reg_wide && (reg_addr == ADDR_RESULT_HI);
    endsequence

    a_start_mode: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_01]
        conv_start |-> trig_mode_q)
        else $error("start seen in software trigger mode");

    a_start_source: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_02]
        trig_mode_q |-> (conv_start == (trig_src_q ? timer8b_irq : timer0_compare_irq)))
        else $error("wrong timer source drives start");

    a_neg_ref: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_04]
        s_ref_write |=> (neg_reference_select == $past(reg_wdata[NEG_REF_POS])))
        else $error("negative reference not taken from bit 7");

    a_booster_bit: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_05]
        s_ref_write |=> (booster_enable == $past(reg_wdata[BOOST_EN_POS])))
        else $error("booster enable not taken from bit 1");

    a_boost_wait: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_06]
        $rose(booster_enable) |-> (bst_q != BST_READY) [*8])
        else $error("booster ready before settle time");

    a_result_load: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_08]
        conv_done |=> (result_q == $past(sar_result)) && fresh_q)
        else $error("result not reloaded at conversion end");

    a_wide_read: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_10]
        s_wide_read |=> (reg_rdata == {4'h0, $past(result_q)}))
        else $error("wide result read wrong");

    a_high8_view: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_13]
        s_byte_hi_read |=> (reg_rdata == {8'h00, $past(result_q[11:4])}))
        else $error("upper byte read is not result bits 11..4");

    a_chan_prohib: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_14]
        (chan_q == CHAN_PROHIBITED) |-> chan_prohibited && (chan_onehot == 16'h0000))
        else $error("prohibited channel code selects an input");

    a_chan_extra: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_19]
        (chan_q == 4'hB) || (chan_q == 4'hF) |-> !chan_prohibited)
        else $error("inputs 11 or 15 not selectable");

    a_amp_route: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_18]
        amp_out_route[1] |-> amp_in_use[1] && (chan_q == 4'h4))
        else $error("amplifier routed while not in use");

    a_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_09]
        !reg_rd |=> (reg_rdata == 16'h0000))
        else $error("read data outside the read answer cycle");

endmodule
`default_nettype wire

// >>> tb/adc_far_model.sv
// far-side model: converter core answering start requests with a SAR value
// assumes starts are one-cycle pulses on mclk; one conversion at a time
`timescale 1ns/10ps
`default_nettype none
module adc_far_model #(
    parameter int LAT = 3
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // start request and value to convert
    input  wire logic        start,
    input  wire logic [11:0] value,
    // conversion end
    output logic             conv_done,
    output logic      [11:0] sar_result
);
    logic [3:0]  cnt_q;
    logic [11:0] val_q;
    logic [11:0] last_q;

    // ------------------------------------------------------------------
    // conversion timer
    // ------------------------------------------------------------------
    // counts the conversion time, then pulses done with the value
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_q     <= 4'h0;
            conv_done <= 1'b0;
            val_q     <= 12'h000;
            last_q    <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    conv_done <= 1'b1;
                    last_q    <= val_q;
                end
            end else if (start) begin
                cnt_q <= 4'(LAT);
                val_q <= value;
            end
        end
    end

    // value is only held in the done cycle; inverted otherwise
    assign sar_result = conv_done ? last_q : ~last_q;
endmodule
`default_nettype wire

// >>> tb/adc_trigger_ref_result_regs_tb_top.sv
// testbench: register tasks, conversions, triggers and channel decode
// assumes adc_ctrl with short settle counts and the far-side model
`timescale 1ns/10ps
`default_nettype none
module adc_trigger_ref_result_regs_tb_top
    import adc_pkg::*;
;
    localparam int BW = 16;
    localparam int CW = 4;
    logic        mclk, nrst, reg_wr, reg_rd, reg_wide, conversion_run, comparator_enable;
    logic        timer0_compare_irq, timer8b_irq, sw_go, conv_done, conv_start;
    logic        neg_reference_select, booster_enable, chan_prohibited;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, chan_onehot, r;
    logic [11:0] go_value, sar_result;
    logic [2:0]  amp_in_use, amp_out_route;
    logic [15:0] regs [5] = '{ADDR_RESULT_LO, ADDR_RESULT_HI, ADDR_REF_BOOST,
                              ADDR_CHAN_SEL, ADDR_TRIG_CTRL};
    logic [7:0]  rb [3] = '{8'h80, 8'h02, 8'h82};
    logic [11:0] cv [2] = '{12'hABC, 12'h5F3};
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    adc_ctrl #(.BOOST_WAIT(BW), .CMP_WAIT(CW)) dut_u (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wide(reg_wide), .reg_rdata(reg_rdata),
        .conversion_run(conversion_run), .comparator_enable(comparator_enable),
        .conv_done(conv_done), .sar_result(sar_result), .conv_start(conv_start),
        .timer0_compare_irq(timer0_compare_irq), .timer8b_irq(timer8b_irq),
        .amp_in_use(amp_in_use), .neg_reference_select(neg_reference_select),
        .booster_enable(booster_enable), .chan_onehot(chan_onehot),
        .chan_prohibited(chan_prohibited), .amp_out_route(amp_out_route));

    adc_far_model far_u (.mclk(mclk), .nrst(nrst), .start(sw_go | conv_start),
        .value(go_value), .conv_done(conv_done), .sar_result(sar_result));

    // ------------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // cut a hang short
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wide  <= 1'b0;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wide <= w;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // waits for conversion end, then lets the result load
    task automatic wait_done();
        int k = 0;
        while (conv_done !== 1'b1 && k < 50) begin
            @(negedge mclk);
            k++;
        end
        check(16'(k < 50), 16'h0001);
        @(posedge mclk);
        #1;
    endtask

    task automatic convert(input logic [11:0] v);
        @(posedge mclk);
        go_value <= v;
        sw_go    <= 1'b1;
        @(posedge mclk);
        sw_go <= 1'b0;
        wait_done();
    endtask

    // pulses one timer event and checks the start output in that cycle
    task automatic pulse(input logic t, input logic exp);
        @(posedge mclk);
        timer0_compare_irq <= ~t;
        timer8b_irq        <= t;
        @(negedge mclk);
        check(16'(conv_start), 16'(exp));
        @(posedge mclk);
        timer0_compare_irq <= 1'b0;
        timer8b_irq        <= 1'b0;
        if (exp)
            wait_done();
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {nrst, reg_wr, reg_rd, reg_wide, conversion_run, comparator_enable} = 6'h00;
        {timer0_compare_irq, timer8b_irq, sw_go} = 3'h0;
        {reg_addr, reg_wdata, go_value, amp_in_use} = '0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        // reset values of all registers except status
        for (int i = 0; i < 5; i++) begin
            rd(regs[i], 1'b0, r);
            check(r, 16'h0000);
        end
        check(chan_onehot, 16'h0001);
        // reference and booster bits, ending with the booster on
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_REF_BOOST, {8'h00, rb[i]});
            check({14'h0, neg_reference_select, booster_enable}, {14'h0, rb[i][7], rb[i][1]});
            rd(ADDR_REF_BOOST, 1'b0, r);
            check(r, {8'h00, rb[i]});
        end
        // booster only just started: nothing settled yet
        rd(ADDR_STATUS, 1'b0, r);
        check(r, 16'h0000);
        // settle booster, then comparator, before starting
        repeat (BW + 2) @(posedge mclk);
        comparator_enable <= 1'b1;
        repeat (CW + 2) @(posedge mclk);
        rd(ADDR_STATUS, 1'b0, r);
        check(r, 16'h0003);
        // software conversions, each read as wide, low byte and high view
        conversion_run <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            convert(cv[i]);
            rd(ADDR_STATUS, 1'b0, r);
            check(r, 16'h000B);
            rd(ADDR_RESULT_LO, 1'b1, r);
            check(r, {4'h0, cv[i]});
            rd(ADDR_RESULT_LO, 1'b0, r);
            check(r, {8'h00, cv[i][7:0]});
            rd(ADDR_RESULT_HI, 1'b0, r);
            check(r, {8'h00, cv[i][11:4]});
        end
        // trigger mode and source table, written only while stopped
        @(posedge mclk);
        conversion_run <= 1'b0;
        go_value       <= 12'h3C6;
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr(ADDR_TRIG_CTRL, {8'h00, 1'(m), 6'h00, 1'(s)});
                rd(ADDR_TRIG_CTRL, 1'b0, r);
                check(r, {8'h00, 1'(m), 6'h00, 1'(s)});
                for (int t = 0; t < 2; t++)
                    pulse(1'(t), m == 1 && t == s);
            end
        end
        rd(ADDR_RESULT_LO, 1'b1, r);
        check(r, 16'h03C6);
        wr(ADDR_TRIG_CTRL, 16'h0000);
        // channel codes, prohibited codes, amp routing; pins kept analog
        @(posedge mclk);
        amp_in_use <= 3'b111;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_CHAN_SEL, 16'(c));
            if (c <= 6 || (c >= 8 && c <= 11) || c == 15)
                check(chan_onehot, 16'h0001 << c);
            else
                check(chan_onehot, 16'h0000);
            check(16'(chan_prohibited), 16'(c == 7 || c == 12 || c == 13 || c == 14));
            check(16'(amp_out_route), c == 1 ? 16'h1 : c == 4 ? 16'h2 : c == 9 ? 16'h4 : 16'h0);
            rd(ADDR_CHAN_SEL, 1'b0, r);
            check(r, 16'(c));
        end
        @(posedge mclk);
        amp_in_use <= 3'b011;
        wr(ADDR_CHAN_SEL, 16'h0009);
        check(16'(amp_out_route), 16'h0000);
        // result kept across channel writes and an attempted write
        wr(ADDR_RESULT_LO, 16'hFFFF);
        rd(ADDR_RESULT_LO, 1'b1, r);
        check(r, 16'h03C6);
        rd(ADDR_RESULT_HI, 1'b1, r);
        check(r, 16'h0000);
        // result reads have cleared the fresh flag
        rd(ADDR_STATUS, 1'b0, r);
        check(r, 16'h0003);
        rd(16'hFF30, 1'b0, r);
        check(r, 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
